// File: src/eipf_pkg.sv
package eipf_pkg;
	localparam int EIPF_ADDR_W = 12;
	localparam int EIPF_DATA_W = 32;
	// register indices; byte address is four times the index
	localparam logic [9:0] EIPF_IDX_PEND = 10'h0F1;
	localparam logic [9:0] EIPF_IDX_PINSEL = 10'h0F2;
	localparam logic [9:0] EIPF_IDX_PRIO2 = 10'h0F4;
	localparam logic [9:0] EIPF_IDX_PRIO1 = 10'h0F6;
	localparam logic [9:0] EIPF_IDX_EDGE = 10'h0F7;
	localparam logic [9:0] EIPF_IDX_STAT = 10'h080;
	localparam logic [9:0] EIPF_IDX_MASK = 10'h081;
	localparam logic [9:0] EIPF_IDX_STATE = 10'h082;
	localparam logic [7:0] EIPF_RST_PEND = 8'h00;
	localparam logic [7:0] EIPF_RST_PINSEL = 8'h00;
	localparam logic [7:0] EIPF_RST_PRIO = 8'h00;
	localparam logic [7:0] EIPF_RST_EDGE = 8'h15;
	localparam logic [7:0] EIPF_RST_STAT = 8'h00;
	localparam logic [7:0] EIPF_RST_MASK = 8'h00;
	localparam logic [7:0] EIPF_PEND_MASK = 8'h9C;
	localparam logic [7:0] EIPF_PINSEL_MASK = 8'h07;
	localparam logic [7:0] EIPF_PRIO2_MASK = 8'h07;
	localparam logic [7:0] EIPF_PRIO1_MASK = 8'hDC;
	localparam logic [7:0] EIPF_EDGE_MASK = 8'h3F;
	localparam logic [7:0] EIPF_STAT_MASK = 8'h0F;
	localparam int EIPF_PEND_TIMER = 7;
	localparam int EIPF_PEND_CONV = 4;
	localparam int EIPF_PEND_TWI = 3;
	localparam int EIPF_PEND_EXT2 = 2;
	localparam int EIPF_PIN_EXT0 = 0;
	localparam int EIPF_PIN_EXT1 = 1;
	localparam int EIPF_PIN_EXT2 = 2;
	localparam int EIPF_EDGE_EXT0 = 0;
	localparam int EIPF_EDGE_EXT1 = 2;
	localparam int EIPF_EDGE_EXT2 = 4;
	localparam int EIPF_P1_TIMER = 7;
	localparam int EIPF_P1_DISP = 6;
	localparam int EIPF_P1_CONV = 4;
	localparam int EIPF_P1_TWI = 3;
	localparam int EIPF_P1_EXT = 2;
	localparam int EIPF_P2_UART1 = 2;
	localparam int EIPF_P2_UART0 = 1;
	localparam int EIPF_P2_LVD = 0;
	localparam logic [1:0] EIPF_EDGE_FALL = 2'h1;
	localparam logic [1:0] EIPF_EDGE_RISE = 2'h2;
	localparam int EIPF_ST_EXT0 = 0;
	localparam int EIPF_ST_EXT1 = 1;
	localparam int EIPF_ST_EXT2 = 2;
	localparam int EIPF_ST_WAKE = 3;
	// arbitration source numbers, lower wins within a level
	localparam int EIPF_NSRC = 10;
	localparam int EIPF_VEC_W = 4;
	localparam int EIPF_SRC_EXT0 = 0;
	localparam int EIPF_SRC_EXT1 = 1;
	localparam int EIPF_SRC_EXT2 = 2;
	localparam int EIPF_SRC_TIMER = 3;
	localparam int EIPF_SRC_DISP = 4;
	localparam int EIPF_SRC_CONV = 5;
	localparam int EIPF_SRC_TWI = 6;
	localparam int EIPF_SRC_UART0 = 7;
	localparam int EIPF_SRC_UART1 = 8;
	localparam int EIPF_SRC_LVD = 9;
	localparam logic [1:0] EIPF_RESP_OKAY = 2'h0;
	localparam logic [1:0] EIPF_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		EIPF_NEST_IDLE = 2'h0,
		EIPF_NEST_LOW = 2'h1,
		EIPF_NEST_BOTH = 2'h3,
		EIPF_NEST_HIGH = 2'h2
	} eipf_nest_t;
endpackage

// File: src/eipf_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eipf_edge_if;
	logic [2:0] pin_enable;
	logic [5:0] edge_sel;
	logic [2:0] edge_event;
	logic [2:0] pin_low_wake;
	modport ctrl(output pin_enable, output edge_sel,
		input edge_event, input pin_low_wake);
	modport det(input pin_enable, input edge_sel,
		output edge_event, output pin_low_wake);
endinterface
`default_nettype wire

// File: src/eipf_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module eipf_edge_det
	import eipf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [2:0] pins,
	eipf_edge_if.det edge_bus
);
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] prev_reg;
	logic [2:0] event_reg;
	logic [2:0] wake_reg;
	logic [2:0] hit_w;
	logic [2:0] wake_w;

	function automatic logic edge_hit(input logic [1:0] sel,
		input logic prev, input logic cur);
		case (sel)
			EIPF_EDGE_FALL: edge_hit = prev & ~cur;
			EIPF_EDGE_RISE: edge_hit = ~prev & cur;
			default: edge_hit = prev ^ cur;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ch
			assign hit_w[g] = edge_bus.pin_enable[g] &
				edge_hit(edge_bus.edge_sel[2*g +: 2], prev_reg[g],
				sync2_reg[g]);
			assign wake_w[g] = edge_bus.pin_enable[g] & ~sync2_reg[g] &
				(edge_bus.edge_sel[2*g +: 2] != EIPF_EDGE_RISE);
		end
	endgenerate

	// pins idle high, so the chain starts high
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_reg <= 3'h7;
			sync2_reg <= 3'h7;
			prev_reg <= 3'h7;
			event_reg <= 3'h0;
			wake_reg <= 3'h0;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			event_reg <= hit_w;
			wake_reg <= wake_w;
		end
	end

	assign edge_bus.edge_event = event_reg;
	assign edge_bus.pin_low_wake = wake_reg;
endmodule
`default_nettype wire

// File: src/eipf_top.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module eipf_top
	import eipf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [EIPF_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [EIPF_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [EIPF_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [EIPF_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic port_d_pin_zero,
	input wire logic port_d_pin_six,
	input wire logic port_d_pin_seven,
	input wire logic timer_watchdog_event,
	input wire logic converter_event,
	input wire logic twowire_event,
	input wire logic display_req,
	input wire logic uart0_req,
	input wire logic uart1_req,
	input wire logic low_voltage_detect_req,
	input wire logic core_irq_ack,
	input wire logic core_irq_return,
	output logic core_irq_req,
	output logic [EIPF_VEC_W-1:0] core_irq_vector,
	output logic core_irq_high,
	output logic irq,
	output logic low_power_wake
);
	eipf_edge_if edge_bus();

	logic awready_reg;
	logic wready_reg;
	logic [EIPF_ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [EIPF_DATA_W-1:0] rdata_reg;

	logic [7:0] pend_reg;
	logic [7:0] pinsel_reg;
	logic [7:0] prio2_reg;
	logic [7:0] prio1_reg;
	logic [7:0] edge_reg;
	logic [7:0] stat_reg;
	logic [7:0] mask_reg;
	logic [1:0] ext01_pend_reg;
	logic irq_reg;
	logic wake_reg;
	eipf_nest_t nest_reg;
	eipf_nest_t nest_next;
	logic req_reg;
	logic [EIPF_VEC_W-1:0] vec_reg;
	logic high_reg;

	function automatic logic idx_hit(input logic [EIPF_ADDR_W-1:0] addr,
		input logic [9:0] idx);
		idx_hit = (addr[EIPF_ADDR_W-1:2] == idx);
	endfunction

	function automatic logic mapped(input logic [EIPF_ADDR_W-1:0] addr);
		mapped = idx_hit(addr, EIPF_IDX_PEND) |
			idx_hit(addr, EIPF_IDX_PINSEL) |
			idx_hit(addr, EIPF_IDX_PRIO2) |
			idx_hit(addr, EIPF_IDX_PRIO1) |
			idx_hit(addr, EIPF_IDX_EDGE) |
			idx_hit(addr, EIPF_IDX_STAT) |
			idx_hit(addr, EIPF_IDX_MASK) |
			idx_hit(addr, EIPF_IDX_STATE);
	endfunction

	// lowest set source number, with a found flag on top
	function automatic logic [EIPF_VEC_W:0] first_set(
		input logic [EIPF_NSRC-1:0] v);
		first_set = '0;
		for (int i = EIPF_NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = {1'b1, i[EIPF_VEC_W-1:0]};
			end
		end
	endfunction

	// write path: address and data are taken in either order
	wire aw_take = s_axi_awvalid & awready_reg;
	wire w_take = s_axi_wvalid & wready_reg;
	wire wr_go = ~awready_reg & ~wready_reg & ~bvalid_reg;
	wire wr_lane = wr_go & wstrb_reg;
	wire we_pend = wr_lane & idx_hit(awaddr_reg, EIPF_IDX_PEND);
	wire we_pinsel = wr_lane & idx_hit(awaddr_reg, EIPF_IDX_PINSEL);
	wire we_prio2 = wr_lane & idx_hit(awaddr_reg, EIPF_IDX_PRIO2);
	wire we_prio1 = wr_lane & idx_hit(awaddr_reg, EIPF_IDX_PRIO1);
	wire we_edge = wr_lane & idx_hit(awaddr_reg, EIPF_IDX_EDGE);
	wire we_stat = wr_lane & idx_hit(awaddr_reg, EIPF_IDX_STAT);
	wire we_mask = wr_lane & idx_hit(awaddr_reg, EIPF_IDX_MASK);
	wire b_done = bvalid_reg & s_axi_bready;
	wire ar_take = s_axi_arvalid & arready_reg;
	wire r_done = rvalid_reg & s_axi_rready;

	// pin events from the detector
	wire [2:0] ev = edge_bus.edge_event;
	wire wake_now = |edge_bus.pin_low_wake;
	wire wake_rise = wake_now & ~wake_reg;

	assign edge_bus.pin_enable = pinsel_reg[2:0];
	assign edge_bus.edge_sel = edge_reg[5:0];

	// hardware sets win over a software write in the same cycle
	wire [7:0] pend_set = {timer_watchdog_event, 2'h0, converter_event,
		twowire_event, ev[EIPF_PIN_EXT2], 2'h0};
	wire [7:0] pend_base = we_pend ? wdata_reg : pend_reg;
	wire [7:0] pend_next = (pend_base | pend_set) & EIPF_PEND_MASK;

	wire [7:0] stat_set = {4'h0, wake_rise, ev};
	wire [7:0] stat_clr = we_stat ? wdata_reg : 8'h00;
	wire [7:0] stat_next = ((stat_reg & ~stat_clr) | stat_set) &
		EIPF_STAT_MASK;

	// arbitration
	wire ack_ok = core_irq_ack & req_reg;
	wire [1:0] ack_ext = {ack_ok & (vec_reg == EIPF_VEC_W'(EIPF_SRC_EXT1)),
		ack_ok & (vec_reg == EIPF_VEC_W'(EIPF_SRC_EXT0))};
	wire [1:0] ext01_next = (ext01_pend_reg & ~ack_ext) |
		ev[EIPF_PIN_EXT1:EIPF_PIN_EXT0];

	wire [EIPF_NSRC-1:0] pend_vec = {low_voltage_detect_req, uart1_req,
		uart0_req, pend_reg[EIPF_PEND_TWI], pend_reg[EIPF_PEND_CONV],
		display_req, pend_reg[EIPF_PEND_TIMER], pend_reg[EIPF_PEND_EXT2],
		ext01_pend_reg[1], ext01_pend_reg[0]};
	wire [EIPF_NSRC-1:0] prio_vec = {prio2_reg[EIPF_P2_LVD],
		prio2_reg[EIPF_P2_UART1], prio2_reg[EIPF_P2_UART0],
		prio1_reg[EIPF_P1_TWI], prio1_reg[EIPF_P1_CONV],
		prio1_reg[EIPF_P1_DISP], prio1_reg[EIPF_P1_TIMER],
		prio1_reg[EIPF_P1_EXT], prio1_reg[EIPF_P1_EXT],
		prio1_reg[EIPF_P1_EXT]};
	wire [EIPF_VEC_W:0] hi_pick = first_set(pend_vec & prio_vec);
	wire [EIPF_VEC_W:0] lo_pick = first_set(pend_vec & ~prio_vec);
	// high may interrupt a low handler, low only runs from idle
	wire hi_ok = hi_pick[EIPF_VEC_W] &
		((nest_reg == EIPF_NEST_IDLE) | (nest_reg == EIPF_NEST_LOW));
	wire lo_ok = lo_pick[EIPF_VEC_W] & (nest_reg == EIPF_NEST_IDLE);
	wire req_next = (hi_ok | lo_ok) & ~core_irq_ack;
	wire [EIPF_VEC_W-1:0] vec_next = hi_ok ? hi_pick[EIPF_VEC_W-1:0] :
		lo_pick[EIPF_VEC_W-1:0];

	always_comb begin
		nest_next = nest_reg;
		if (ack_ok) begin
			case (nest_reg)
				EIPF_NEST_IDLE: nest_next = high_reg ? EIPF_NEST_HIGH :
					EIPF_NEST_LOW;
				EIPF_NEST_LOW: nest_next = EIPF_NEST_BOTH;
				default: nest_next = nest_reg;
			endcase
		end else if (core_irq_return) begin
			case (nest_reg)
				EIPF_NEST_HIGH: nest_next = EIPF_NEST_IDLE;
				EIPF_NEST_BOTH: nest_next = EIPF_NEST_LOW;
				EIPF_NEST_LOW: nest_next = EIPF_NEST_IDLE;
				default: nest_next = EIPF_NEST_IDLE;
			endcase
		end
	end

	// read selection
	wire [7:0] state_rd = {3'h0, wake_reg, nest_reg, ext01_pend_reg};
	wire [7:0] rd_byte =
		idx_hit(s_axi_araddr, EIPF_IDX_PEND) ? pend_reg :
		idx_hit(s_axi_araddr, EIPF_IDX_PINSEL) ? pinsel_reg :
		idx_hit(s_axi_araddr, EIPF_IDX_PRIO2) ? prio2_reg :
		idx_hit(s_axi_araddr, EIPF_IDX_PRIO1) ? prio1_reg :
		idx_hit(s_axi_araddr, EIPF_IDX_EDGE) ? edge_reg :
		idx_hit(s_axi_araddr, EIPF_IDX_STAT) ? stat_reg :
		idx_hit(s_axi_araddr, EIPF_IDX_MASK) ? mask_reg :
		idx_hit(s_axi_araddr, EIPF_IDX_STATE) ? state_rd : 8'h00;
	wire [1:0] rd_resp = mapped(s_axi_araddr) ? EIPF_RESP_OKAY :
		EIPF_RESP_SLVERR;
	wire [1:0] wr_resp = mapped(awaddr_reg) ? EIPF_RESP_OKAY :
		EIPF_RESP_SLVERR;

	always_ff @(posedge clk) begin
		if (srst) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= EIPF_RESP_OKAY;
		end else begin
			if (aw_take) begin
				awready_reg <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_reg <= 1'b0;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_resp;
			end
			if (b_done) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= EIPF_RESP_OKAY;
			rdata_reg <= '0;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= rd_resp;
			rdata_reg <= {24'h000000, rd_byte};
		end else if (r_done) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pend_reg <= EIPF_RST_PEND;
			pinsel_reg <= EIPF_RST_PINSEL;
			prio2_reg <= EIPF_RST_PRIO;
			prio1_reg <= EIPF_RST_PRIO;
			edge_reg <= EIPF_RST_EDGE;
			mask_reg <= EIPF_RST_MASK;
		end else begin
			pend_reg <= pend_next;
			if (we_pinsel) begin
				pinsel_reg <= wdata_reg & EIPF_PINSEL_MASK;
			end
			if (we_prio2) begin
				prio2_reg <= wdata_reg & EIPF_PRIO2_MASK;
			end
			if (we_prio1) begin
				prio1_reg <= wdata_reg & EIPF_PRIO1_MASK;
			end
			if (we_edge) begin
				edge_reg <= wdata_reg & EIPF_EDGE_MASK;
			end
			if (we_mask) begin
				mask_reg <= wdata_reg & EIPF_STAT_MASK;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			stat_reg <= EIPF_RST_STAT;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			ext01_pend_reg <= 2'h0;
			nest_reg <= EIPF_NEST_IDLE;
			req_reg <= 1'b0;
			vec_reg <= '0;
			high_reg <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			irq_reg <= |(stat_reg & mask_reg);
			wake_reg <= wake_now;
			ext01_pend_reg <= ext01_next;
			nest_reg <= nest_next;
			req_reg <= req_next;
			vec_reg <= vec_next;
			high_reg <= hi_ok;
		end
	end

	eipf_edge_det u_edge (
		.clk(clk),
		.srst(srst),
		.pins({port_d_pin_seven, port_d_pin_six, port_d_pin_zero}),
		.edge_bus(edge_bus)
	);

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign core_irq_req = req_reg;
	assign core_irq_vector = vec_reg;
	assign core_irq_high = high_reg;
	assign irq = irq_reg;
	assign low_power_wake = wake_reg;
endmodule
`default_nettype wire

// File: verif/eipf_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eipf_asserts
	import eipf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [EIPF_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [EIPF_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [EIPF_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [EIPF_DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic port_d_pin_zero,
	input wire logic port_d_pin_six,
	input wire logic port_d_pin_seven,
	input wire logic core_irq_ack,
	input wire logic core_irq_req,
	input wire logic irq,
	input wire logic low_power_wake
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire pins_high = port_d_pin_zero && port_d_pin_six && port_d_pin_seven;
	reset_quiet_a: assert property ($fell(srst) |-> !s_axi_bvalid
		&& !s_axi_rvalid && !core_irq_req && !irq && s_axi_awready)
		else $error("outputs not idle after reset");
	write_resp_a: assert property (aw_take && w_take |->
		!s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after take");
	write_busy_a: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write channel ready during response");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after take");
	read_upper_a: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == 12'h000 |=> s_axi_rresp == 2'h2
		&& s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	ack_drop_a: assert property (
		core_irq_ack && core_irq_req |=> !core_irq_req)
		else $error("request still high after ack");
	wake_idle_a: assert property (
		pins_high [*6] |-> !low_power_wake)
		else $error("wake with all pins high");
	mask_off_a: assert property (aw_take && w_take && s_axi_wstrb[0]
		&& s_axi_awaddr == 12'h204 && s_axi_wdata[3:0] == 4'h0
		|-> ##4 !irq)
		else $error("irq high with mask cleared");
endmodule
bind eipf_top eipf_asserts u_asserts (.*);
`default_nettype wire

// File: verif/eipf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module eipf_core_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic core_irq_req,
	input wire logic [3:0] ack_delay,
	output logic core_irq_ack,
	output logic core_irq_return
);
	int waited;
	int depth;
	int hold;
	always @(posedge clk) begin
		core_irq_ack <= 1'b0;
		core_irq_return <= 1'b0;
		if (srst) begin
			waited = 0;
			depth = 0;
			hold = 0;
		end else begin
			waited = (core_irq_req && !core_irq_ack) ? waited + 1 : 0;
			if (waited > ack_delay) begin
				// a new request inside a handler nests one level
				core_irq_ack <= 1'b1;
				depth++;
				hold = 8;
				waited = 0;
			end else if (depth > 0) begin
				hold--;
				if (hold == 0) begin
					core_irq_return <= 1'b1;
					depth--;
					hold = 8;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/eipf_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module eipf_top_test;
	import eipf_pkg::*;
	logic clk = 0, srst = 1, fall, rise;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, core_irq_vector, ack_delay = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp, c;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic display_req = 0, uart0_req = 0, uart1_req = 0;
	logic low_voltage_detect_req = 0, core_irq_ack, core_irq_return;
	logic core_irq_req, core_irq_high, irq, low_power_wake;
	logic [2:0] pins = 3'h7, ev = 3'h0, e3;
	logic [7:0] d;
	logic [9:0] ix [4] = '{EIPF_IDX_PINSEL, EIPF_IDX_PRIO2,
		EIPF_IDX_PRIO1, EIPF_IDX_EDGE};
	logic [7:0] mk [4] = '{EIPF_PINSEL_MASK, EIPF_PRIO2_MASK,
		EIPF_PRIO1_MASK, EIPF_EDGE_MASK};
	logic [33:0] rq [$];
	logic [1:0] bq [$];
	int bad_count = 0, checks = 0, i, m, k;
	wire port_d_pin_zero = pins[0];
	wire port_d_pin_six = pins[1];
	wire port_d_pin_seven = pins[2];
	wire timer_watchdog_event = ev[2];
	wire converter_event = ev[1];
	wire twowire_event = ev[0];
	wire [5:0] pick = {core_irq_req, core_irq_high, core_irq_vector};
	eipf_top u_dut (.*);
	eipf_core_model u_core (.*);
	always #4 clk = ~clk;
	task automatic chk(input string n, input logic [33:0] e,
		input logic [33:0] g);
		checks++;
		if (e !== g) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] v,
		input logic [1:0] r = 2'h0);
		@(posedge clk);
		bq.push_back(r);
		s_axi_awaddr <= {a, 2'h0};
		s_axi_wdata <= {24'($urandom), v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] v,
		input logic [1:0] r = 2'h0);
		@(posedge clk);
		rq.push_back({r, 24'h0, v});
		s_axi_araddr <= {a, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
	end
	initial begin
		ticks(5000);
		bad_count++;
		complete_run();
	end
	initial begin
		void'($urandom(32'hF8EB6560));
		ticks(3);
		srst <= 1'b0;
		rd(EIPF_IDX_PEND, 8'h00);
		rd(EIPF_IDX_PINSEL, 8'h00);
		rd(EIPF_IDX_PRIO2, 8'h00);
		rd(EIPF_IDX_PRIO1, 8'h00);
		rd(EIPF_IDX_EDGE, 8'h15);
		rd(10'h000, 8'h00, 2'h2);
		wr(10'h000, 8'hFF, 2'h2);
		for (i = 0; i < 4; i++) begin
			d = 8'($urandom);
			wr(ix[i], d);
			rd(ix[i], d & mk[i]);
		end
		d = 8'($urandom);
		wr(EIPF_IDX_PEND, d);
		rd(EIPF_IDX_PEND, d & 8'h9C);
		wr(EIPF_IDX_PEND, 8'h00);
		rd(EIPF_IDX_PEND, 8'h00);
		e3 = 3'($urandom_range(1, 7));
		ev <= e3;
		ticks(1);
		ev <= 3'h0;
		rd(EIPF_IDX_PEND, {e3[2], 2'h0, e3[1:0], 3'h0});
		wr(EIPF_IDX_PEND, 8'h00);
		// let earlier handlers unwind before arbitration checks
		ticks(40);
		rd(EIPF_IDX_STATE, 8'h00);
		// slow core so the pending request stays visible
		ack_delay <= 4'hF;
		wr(EIPF_IDX_PRIO1, 8'h40);
		wr(EIPF_IDX_PRIO2, 8'h04);
		ev <= 3'h4;
		ticks(1);
		ev <= 3'h0;
		ticks(3);
		chk("vector", 34'h23, 34'(pick));
		display_req <= 1'b1;
		ticks(3);
		chk("vector", 34'h34, 34'(pick));
		display_req <= 1'b0;
		uart0_req <= 1'b1;
		uart1_req <= 1'b1;
		ticks(3);
		chk("vector", 34'h38, 34'(pick));
		uart0_req <= 1'b0;
		uart1_req <= 1'b0;
		wr(EIPF_IDX_PEND, 8'h00);
		for (m = 0; m < 5; m++) begin
			for (k = 0; k < 3; k++) begin
				ack_delay <= 4'($urandom_range(0, 3));
				c = m[1:0];
				fall = (m < 4) && c != EIPF_EDGE_RISE;
				rise = (m < 4) && c != EIPF_EDGE_FALL;
				wr(EIPF_IDX_PINSEL, (m < 4) ? 8'h07 : 8'h00);
				wr(EIPF_IDX_EDGE, {2'h0, c, c, c});
				wr(EIPF_IDX_MASK, (m == 3) ? 8'h00 : 8'h0F);
				wr(EIPF_IDX_STAT, 8'h0F);
				wr(EIPF_IDX_PEND, 8'h00);
				pins[k] <= 1'b0;
				ticks(8);
				chk("wake", 34'(fall), 34'(low_power_wake));
				chk("irq", 34'(fall && m != 3), 34'(irq));
				rd(EIPF_IDX_STAT, fall ? 8'h08 | (8'h01 << k) : 8'h00);
				rd(EIPF_IDX_PEND, (fall && k == 2) ? 8'h04 : 8'h00);
				wr(EIPF_IDX_STAT, 8'h0F);
				pins[k] <= 1'b1;
				ticks(8);
				rd(EIPF_IDX_STAT, rise ? 8'h01 << k : 8'h00);
			end
		end
		srst <= 1'b1;
		ticks(3);
		srst <= 1'b0;
		rd(EIPF_IDX_EDGE, 8'h15);
		ticks(5);
		complete_run();
	end
endmodule
`default_nettype wire
